// [pcbar_checker_assertions.sv]
// Port checker for the configuration header bank.
`timescale 1ns/1ps
module pcbar_checker (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register port.
    input wire logic reg_req_i,
    input wire logic reg_we_i,
    input wire logic reg_cfg_space_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_err_o,
    input wire logic [31:0] reg_rdata_o,
    input wire logic satellite_mode_i,
    // Decode and burst.
    input wire logic memory_response_enable_i,
    input wire logic pci_addr_valid_i,
    input wire logic [2:0] pci_hit_o,
    input wire logic burst_req_i,
    input wire logic [7:0] burst_len_i,
    input wire logic read_cmd_valid_o,
    input wire logic [3:0] read_cmd_o,
    // Views.
    input wire logic [7:0] line_size_o,
    input wire logic [7:0] bus_tenure_timer_o
);
    logic rd;
    logic [3:0] exp_cmd;
    assign rd = reg_req_i && !reg_we_i && !satellite_mode_i && !reg_cfg_space_i;
    always_comb
    begin
        if (line_size_o == 8'h00 || burst_len_i < line_size_o)
            exp_cmd = pcbar_pkg::CMD_MEM_READ;
        else if ({1'b0, burst_len_i} >= {line_size_o, 1'b0})
            exp_cmd = pcbar_pkg::CMD_MEM_READ_MULT;
        else
            exp_cmd = pcbar_pkg::CMD_MEM_READ_LINE;
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    AST_SAT_ERR: assert property (
        reg_req_i && satellite_mode_i |=> reg_err_o && reg_rdata_o == 32'h0000_0000)
        else $error("subordinate mode access not refused");
    AST_HDR_FIXED: assert property (
        rd && reg_addr_i == 16'hd00c |=> reg_rdata_o[31:23] == 9'h000)
        else $error("fixed header bits not zero");
    AST_TIMER_LOW: assert property (bus_tenure_timer_o[1:0] == 2'b00)
        else $error("timer low bits not zero");
    AST_WIN0_LOW: assert property (
        rd && reg_addr_i == 16'hd010 |=> reg_rdata_o[28:0] == 29'h0000_0008)
        else $error("window 0 low bits wrong");
    AST_WIN1_LOW: assert property (
        rd && reg_addr_i == 16'hd018 |=> reg_rdata_o[23:0] == 24'h00_0008)
        else $error("window 1 low bits wrong");
    AST_WIN2_LOW: assert property (
        rd && reg_addr_i == 16'hd020 |=> reg_rdata_o[19:0] == 20'h0_0000)
        else $error("window 2 low bits wrong");
    AST_UPPER_ZERO: assert property (
        rd && (reg_addr_i == 16'hd014 || reg_addr_i == 16'hd01c) |=> reg_rdata_o == 0)
        else $error("upper base half not zero");
    AST_NO_CLAIM: assert property (
        !(pci_addr_valid_i && memory_response_enable_i) |=> pci_hit_o == 3'b000)
        else $error("claim without enabled address phase");
    AST_BURST_CMD: assert property (
        burst_req_i |=> read_cmd_valid_o && read_cmd_o == $past(exp_cmd))
        else $error("burst read command wrong");
endmodule

bind pcbar_top pcbar_checker i_pcbar_checker (.*);

// [pcbar_pkg.sv]
// Constants, offsets, field layouts and types shared by the configuration header bank.
package pcbar_pkg;

    // Local register offsets.
    localparam logic [15:0] ADDR_CLASS_REV = 16'hd008;
    localparam logic [15:0] ADDR_HDR_CFG = 16'hd00c;
    localparam logic [15:0] ADDR_WIN0_LO = 16'hd010;
    localparam logic [15:0] ADDR_WIN0_HI = 16'hd014;
    localparam logic [15:0] ADDR_WIN1_LO = 16'hd018;
    localparam logic [15:0] ADDR_WIN1_HI = 16'hd01c;
    localparam logic [15:0] ADDR_WIN2 = 16'hd020;

    // Matching configuration space offsets.
    localparam logic [7:0] CFG_CLASS_REV = 8'h08;
    localparam logic [7:0] CFG_HDR_CFG = 8'h0c;
    localparam logic [7:0] CFG_WIN0_LO = 8'h10;
    localparam logic [7:0] CFG_WIN0_HI = 8'h14;
    localparam logic [7:0] CFG_WIN1_LO = 8'h18;
    localparam logic [7:0] CFG_WIN1_HI = 8'h1c;
    localparam logic [7:0] CFG_WIN2 = 8'h20;

    // Field positions inside the class and configuration words.
    localparam int CLASS_LSB = 8;
    localparam int HDR_LSB = 16;
    localparam int TIMER_LSB = 8;
    localparam int LINE_LSB = 0;

    // Reset values.
    localparam logic [23:0] CLASS_RST = 24'h06_0000;
    localparam logic [6:0] HDR_RST = 7'h00;
    localparam logic [7:0] TIMER_RST = 8'h00;
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [31:0] BAR_RST = 32'h0000_0000;

    // Writable bits of the timer and of the three base registers.
    localparam logic [7:0] TIMER_MASK = 8'hfc;
    localparam logic [31:0] WIN0_MASK = 32'he000_0000;
    localparam logic [31:0] WIN1_MASK = 32'hff00_0000;
    localparam logic [31:0] WIN2_MASK = 32'hfff0_0000;

    // Fixed low bits: prefetch flag in bit 3, type 00, space indicator bit 0.
    localparam logic [31:0] WIN0_FIXED = 32'h0000_0008;
    localparam logic [31:0] WIN1_FIXED = 32'h0000_0008;
    localparam logic [31:0] WIN2_FIXED = 32'h0000_0000;
    localparam logic [2:0] WIN_PREFETCH = 3'h3;

    // Bus commands.
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CLASS_REV,
        SEL_HDR_CFG,
        SEL_WIN0_LO,
        SEL_WIN0_HI,
        SEL_WIN1_LO,
        SEL_WIN1_HI,
        SEL_WIN2
    } pcbar_sel_type;

    typedef enum logic [1:0] {
        TEN_IDLE,
        TEN_COUNT,
        TEN_EXPIRED
    } pcbar_tenure_type;

endpackage

// [pcbar_sw_master.sv]
// Software master model that issues single register accesses.
`timescale 1ns/1ps
module pcbar_sw_master (
    // Clock and command.
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic we_i,
    input wire logic cfg_i,
    input wire logic [15:0] addr_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    // Register access port.
    output logic reg_req_o = 1'b0,
    output logic reg_we_o = 1'b0,
    output logic reg_cfg_space_o = 1'b0,
    output logic [15:0] reg_addr_o = 16'h0000,
    output logic [3:0] reg_be_o = 4'h0,
    output logic [31:0] reg_wdata_o = 32'h0000_0000
);
    // Idle address, write, byte-enable and data outputs toggle so a stale value never looks valid; the config-space flag does not.
    always @(posedge clock_i)
    begin
        reg_req_o <= go_i;
        reg_cfg_space_o <= cfg_i;
        reg_addr_o <= go_i ? (cfg_i ? {8'h00, addr_i[7:0]} : addr_i) : ~reg_addr_o;
        reg_we_o <= go_i ? we_i && addr_i[7:0] != 8'h14 && addr_i[7:0] != 8'h1c : ~reg_we_o;
        reg_be_o <= go_i ? be_i : ~reg_be_o;
        reg_wdata_o <= go_i ? wdata_i : ~reg_wdata_o;
    end
endmodule

// [pcbar_top.sv]
// Configuration header bank: class, header word, three memory windows and their use.
// Behaviour
// - Subordinate mode blocks all register access.
// - Class field bits 31:8 resets to host bridge.
// - Class field loads from EEPROM, else read-only.
// - Revision bits 7:0 readable, EEPROM loadable.
// - Self-test flag bit 31 reads zero.
// - Multi-function flag bit 23 reads zero.
// - Header layout bits 22:16, EEPROM loadable only.
// - Tenure timer bits 15:8 ends access after grant loss.
// - Tenure timer low two bits stay zero.
// - Line size picks burst read command.
// - First window bits 31:29 writable, 512 MB.
// - First window prefetchable, 32-bit type.
// - Upper halves of windows have no function.
// - Second window bits 31:24 writable, 16 MB.
// - Second window prefetchable, 32-bit type.
// - Third window bits 31:20 writable, 1 MB.
// - Third window not prefetchable, 32-bit type.
// - Bit 0 of every base reads zero.
// - Windows appear at config offsets 10, 18, 20.
// - Claim memory accesses only when response enabled.
`timescale 1ns/1ps
module pcbar_top #(
    // Default revision; the value is arbitrary.
    parameter logic [7:0] REVISION_DEFAULT = 8'h00
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Register access port.
    input wire logic reg_req_i,
    input wire logic reg_we_i,
    input wire logic reg_cfg_space_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [3:0] reg_be_i,
    input wire logic [31:0] reg_wdata_i,
    output logic reg_ack_o,
    output logic reg_err_o,
    output logic [31:0] reg_rdata_o,
    // Controller mode and command register view.
    input wire logic satellite_mode_i,
    input wire logic memory_response_enable_i,
    // Configuration EEPROM load.
    input wire logic eeprom_load_i,
    input wire logic [23:0] eeprom_class_i,
    input wire logic [7:0] eeprom_revision_i,
    input wire logic [6:0] eeprom_header_i,
    // Target address decode.
    input wire logic pci_addr_valid_i,
    input wire logic [3:0] pci_cmd_i,
    input wire logic [31:0] pci_addr_i,
    output logic [2:0] pci_hit_o,
    output logic pci_hit_prefetch_o,
    // Burst read command selection.
    input wire logic burst_req_i,
    input wire logic [7:0] burst_len_i,
    output logic read_cmd_valid_o,
    output logic [3:0] read_cmd_o,
    // Bus tenure.
    input wire logic master_active_i,
    input wire logic pci_gnt_n_i,
    output logic tenure_expired_o,
    // Configuration views.
    output logic [7:0] line_size_o,
    output logic [7:0] bus_tenure_timer_o
);

    logic [23:0] class_ff;
    logic [7:0] revision_ff;
    logic [6:0] header_ff;
    logic [7:0] timer_ff;
    logic [7:0] line_ff;
    logic [31:0] win0_ff;
    logic [31:0] win1_ff;
    logic [31:0] win2_ff;
    logic ack_ff;
    logic err_ff;
    logic [31:0] rdata_ff;
    logic [2:0] hit_ff;
    logic prefetch_ff;
    logic cmd_valid_ff;
    logic [3:0] cmd_ff;
    logic gnt_s1_ff;
    logic gnt_s2_ff;
    logic gnt_s3_ff;
    logic gnt_n_ff;
    pcbar_pkg::pcbar_tenure_type tenure_ff;
    pcbar_pkg::pcbar_tenure_type nxt_tenure;
    logic [7:0] tenure_cnt_ff;
    logic [7:0] nxt_tenure_cnt;
    logic expired_ff;
    pcbar_pkg::pcbar_sel_type sel;
    logic wr_ok;
    logic [31:0] rd_word;
    logic [31:0] hdr_word;
    logic [31:0] merged;
    logic [2:0] hit_raw;

    // Maps a local address or a configuration offset to a register.
    function automatic pcbar_pkg::pcbar_sel_type decode_sel(input logic cfg,
                                                           input logic [15:0] addr);
        decode_sel = pcbar_pkg::SEL_NONE;
        // A local address is its configuration offset on the bank's own page.
        if (cfg || addr[15:8] == pcbar_pkg::ADDR_CLASS_REV[15:8])
        begin
            case (addr[7:0])
                pcbar_pkg::CFG_CLASS_REV: decode_sel = pcbar_pkg::SEL_CLASS_REV;
                pcbar_pkg::CFG_HDR_CFG: decode_sel = pcbar_pkg::SEL_HDR_CFG;
                pcbar_pkg::CFG_WIN0_LO: decode_sel = pcbar_pkg::SEL_WIN0_LO;
                pcbar_pkg::CFG_WIN0_HI: decode_sel = pcbar_pkg::SEL_WIN0_HI;
                pcbar_pkg::CFG_WIN1_LO: decode_sel = pcbar_pkg::SEL_WIN1_LO;
                pcbar_pkg::CFG_WIN1_HI: decode_sel = pcbar_pkg::SEL_WIN1_HI;
                pcbar_pkg::CFG_WIN2: decode_sel = pcbar_pkg::SEL_WIN2;
                default: decode_sel = pcbar_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // Byte-lane merge of a write into the old value, keeping only writable bits.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge_bytes = res & mask;
    endfunction

    function automatic logic is_mem_cmd(input logic [3:0] cmd);
        is_mem_cmd = (cmd == pcbar_pkg::CMD_MEM_READ) || (cmd == pcbar_pkg::CMD_MEM_WRITE) ||
                     (cmd == pcbar_pkg::CMD_MEM_READ_MULT) ||
                     (cmd == pcbar_pkg::CMD_MEM_READ_LINE) ||
                     (cmd == pcbar_pkg::CMD_MEM_WRITE_INV);
    endfunction

    assign sel = decode_sel(reg_cfg_space_i, reg_addr_i);
    assign wr_ok = reg_req_i && reg_we_i && !satellite_mode_i;
    assign merged = merge_bytes({16'h0000, timer_ff, line_ff}, reg_wdata_i, reg_be_i,
                                {16'h0000, pcbar_pkg::TIMER_MASK, 8'hff});

    // Self-test and multi-function flags and the reserved bits are constant zero.
    always_comb
    begin
        hdr_word = 32'h0000_0000;
        hdr_word[pcbar_pkg::HDR_LSB +: 7] = header_ff;
        hdr_word[pcbar_pkg::TIMER_LSB +: 8] = timer_ff;
        hdr_word[pcbar_pkg::LINE_LSB +: 8] = line_ff;
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (sel)
            pcbar_pkg::SEL_CLASS_REV: rd_word = {class_ff, revision_ff};
            pcbar_pkg::SEL_HDR_CFG: rd_word = hdr_word;
            pcbar_pkg::SEL_WIN0_LO: rd_word = win0_ff | pcbar_pkg::WIN0_FIXED;
            pcbar_pkg::SEL_WIN1_LO: rd_word = win1_ff | pcbar_pkg::WIN1_FIXED;
            pcbar_pkg::SEL_WIN2: rd_word = win2_ff | pcbar_pkg::WIN2_FIXED;
            pcbar_pkg::SEL_WIN0_HI, pcbar_pkg::SEL_WIN1_HI: rd_word = 32'h0000_0000;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Class and revision change only through an EEPROM load.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            class_ff <= pcbar_pkg::CLASS_RST;
            revision_ff <= REVISION_DEFAULT;
            header_ff <= pcbar_pkg::HDR_RST;
        end
        else if (eeprom_load_i)
        begin
            class_ff <= eeprom_class_i;
            revision_ff <= eeprom_revision_i;
            header_ff <= eeprom_header_i;
        end
    end

    // Timer and line size are the only software-writable bits of the header word.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            timer_ff <= pcbar_pkg::TIMER_RST;
            line_ff <= pcbar_pkg::LINE_RST;
        end
        else if (wr_ok && (sel == pcbar_pkg::SEL_HDR_CFG))
        begin
            timer_ff <= merged[pcbar_pkg::TIMER_LSB +: 8];
            line_ff <= merged[pcbar_pkg::LINE_LSB +: 8];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            win0_ff <= pcbar_pkg::BAR_RST;
            win1_ff <= pcbar_pkg::BAR_RST;
            win2_ff <= pcbar_pkg::BAR_RST;
        end
        else if (wr_ok)
        begin
            if (sel == pcbar_pkg::SEL_WIN0_LO)
            begin
                win0_ff <= merge_bytes(win0_ff, reg_wdata_i, reg_be_i, pcbar_pkg::WIN0_MASK);
            end
            if (sel == pcbar_pkg::SEL_WIN1_LO)
            begin
                win1_ff <= merge_bytes(win1_ff, reg_wdata_i, reg_be_i, pcbar_pkg::WIN1_MASK);
            end
            if (sel == pcbar_pkg::SEL_WIN2)
            begin
                win2_ff <= merge_bytes(win2_ff, reg_wdata_i, reg_be_i, pcbar_pkg::WIN2_MASK);
            end
        end
    end

    // Every request is answered one cycle later; blocked or unmapped ones flag an error.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= reg_req_i;
            err_ff <= reg_req_i && (satellite_mode_i || (sel == pcbar_pkg::SEL_NONE));
            if (reg_req_i && !reg_we_i && !satellite_mode_i)
            begin
                rdata_ff <= rd_word;
            end
            else
            begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    pcbar_win_decode u_win_decode (
        .win0_base_i(win0_ff),
        .win1_base_i(win1_ff),
        .win2_base_i(win2_ff),
        .addr_i(pci_addr_i),
        .enable_i(pci_addr_valid_i && memory_response_enable_i && is_mem_cmd(pci_cmd_i)),
        .hit_o(hit_raw)
    );

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hit_ff <= 3'h0;
            prefetch_ff <= 1'b0;
        end
        else
        begin
            hit_ff <= hit_raw;
            prefetch_ff <= |(hit_raw & pcbar_pkg::WIN_PREFETCH);
        end
    end

    // A burst shorter than a line uses plain read, a line or more read line,
    // two lines or more read multiple; a zero line size always uses plain read.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cmd_valid_ff <= 1'b0;
            cmd_ff <= pcbar_pkg::CMD_MEM_READ;
        end
        else
        begin
            cmd_valid_ff <= burst_req_i;
            if (burst_req_i)
            begin
                if (line_ff == 8'h00 || burst_len_i < line_ff)
                begin
                    cmd_ff <= pcbar_pkg::CMD_MEM_READ;
                end
                else if ({1'b0, burst_len_i} >= {line_ff, 1'b0})
                begin
                    cmd_ff <= pcbar_pkg::CMD_MEM_READ_MULT;
                end
                else
                begin
                    cmd_ff <= pcbar_pkg::CMD_MEM_READ_LINE;
                end
            end
        end
    end

    // Grant pin synchroniser; the level moves once the second and third stages agree.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gnt_s1_ff <= 1'b1;
            gnt_s2_ff <= 1'b1;
            gnt_s3_ff <= 1'b1;
            gnt_n_ff <= 1'b1;
        end
        else
        begin
            gnt_s1_ff <= pci_gnt_n_i;
            gnt_s2_ff <= gnt_s1_ff;
            gnt_s3_ff <= gnt_s2_ff;
            if (gnt_s2_ff == gnt_s3_ff)
            begin
                gnt_n_ff <= gnt_s3_ff;
            end
        end
    end

    always_comb
    begin
        nxt_tenure = tenure_ff;
        nxt_tenure_cnt = tenure_cnt_ff;
        case (tenure_ff)
            pcbar_pkg::TEN_IDLE:
            begin
                nxt_tenure_cnt = 8'h00;
                if (master_active_i && gnt_n_ff)
                begin
                    nxt_tenure = pcbar_pkg::TEN_COUNT;
                end
            end
            pcbar_pkg::TEN_COUNT:
            begin
                if (!master_active_i || !gnt_n_ff)
                begin
                    nxt_tenure = pcbar_pkg::TEN_IDLE;
                end
                else if (tenure_cnt_ff >= timer_ff)
                begin
                    nxt_tenure = pcbar_pkg::TEN_EXPIRED;
                end
                else
                begin
                    nxt_tenure_cnt = tenure_cnt_ff + 8'h01;
                end
            end
            pcbar_pkg::TEN_EXPIRED:
            begin
                if (!master_active_i)
                begin
                    nxt_tenure = pcbar_pkg::TEN_IDLE;
                end
            end
            default:
            begin
                nxt_tenure = pcbar_pkg::TEN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tenure_ff <= pcbar_pkg::TEN_IDLE;
            tenure_cnt_ff <= 8'h00;
            expired_ff <= 1'b0;
        end
        else
        begin
            tenure_ff <= nxt_tenure;
            tenure_cnt_ff <= nxt_tenure_cnt;
            expired_ff <= (nxt_tenure == pcbar_pkg::TEN_EXPIRED);
        end
    end

    assign reg_ack_o = ack_ff;
    assign reg_err_o = err_ff;
    assign reg_rdata_o = rdata_ff;
    assign pci_hit_o = hit_ff;
    assign pci_hit_prefetch_o = prefetch_ff;
    assign read_cmd_valid_o = cmd_valid_ff;
    assign read_cmd_o = cmd_ff;
    assign tenure_expired_o = expired_ff;
    assign line_size_o = line_ff;
    assign bus_tenure_timer_o = timer_ff;

endmodule

// [pcbar_win_decode.sv]
// Address comparator for the three fixed-size target memory windows.
`timescale 1ns/1ps
module pcbar_win_decode (
    // Base registers.
    input wire logic [31:0] win0_base_i,
    input wire logic [31:0] win1_base_i,
    input wire logic [31:0] win2_base_i,
    // Access.
    input wire logic [31:0] addr_i,
    input wire logic enable_i,
    // Result.
    output logic [2:0] hit_o
);

    function automatic logic win_match(input logic [31:0] base, input logic [31:0] addr,
                                       input logic [31:0] mask);
        win_match = ((base & mask) == (addr & mask));
    endfunction

    always_comb
    begin
        hit_o = 3'h0;
        if (enable_i)
        begin
            hit_o[0] = win_match(win0_base_i, addr_i, pcbar_pkg::WIN0_MASK);
            hit_o[1] = win_match(win1_base_i, addr_i, pcbar_pkg::WIN1_MASK);
            hit_o[2] = win_match(win2_base_i, addr_i, pcbar_pkg::WIN2_MASK);
        end
    end

endmodule

// [test_pci_config_header_bars.sv]
// Self-checking bench for the configuration header bank.
`timescale 1ns/1ps
module test_pci_config_header_bars;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic go = 1'b0, we = 1'b0, cfg = 1'b0, sat = 1'b0, mre = 1'b0, ld = 1'b0;
    logic pv = 1'b0, breq = 1'b0, mact = 1'b0, gnt_n = 1'b0, memc;
    logic [15:0] addr = 16'h0000, raddr;
    logic [3:0] be = 4'h0, pcmd = 4'h0, rbe, cmd, ec;
    logic [31:0] wdata = 32'h0000_0000, paddr = 32'h0000_0000, rwd, rdata;
    logic [23:0] ecls = 24'h00_0000, m_cls = 24'h06_0000;
    logic [7:0] erev = 8'h00, blen = 8'h00, line_o, tim_o, m_rev = 8'h00, m_tim = 8'h00;
    logic [7:0] m_line = 8'h00;
    logic [6:0] ehdr = 7'h00, m_hdr = 7'h00;
    logic req, rwe, rcfg, ack, err, hpf, cv, texp;
    logic [2:0] hit, eh;
    logic [31:0] b0 = 32'h0000_0000, b1 = 32'h0000_0000, b2 = 32'h0000_0000, bs[3];
    logic [31:0] msk[3] = '{32'he000_0000, 32'hff00_0000, 32'hfff0_0000};
    logic [15:0] ads[7] = '{16'hd008, 16'hd00c, 16'hd010, 16'hd018, 16'hd020, 16'hd014, 16'hd000};
    logic [3:0] cmds[7] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h2, 4'ha};
    int err_count = 0;
    int total_checks = 0;
    int k, n;

    pcbar_sw_master i_pcbar_sw_master (.clock_i(clock_i), .go_i(go), .we_i(we), .cfg_i(cfg),
        .addr_i(addr), .be_i(be), .wdata_i(wdata), .reg_req_o(req), .reg_we_o(rwe),
        .reg_cfg_space_o(rcfg), .reg_addr_o(raddr), .reg_be_o(rbe), .reg_wdata_o(rwd));
    pcbar_top i_pcbar_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_we_i(rwe),
        .reg_cfg_space_i(rcfg), .reg_addr_i(raddr), .reg_be_i(rbe), .reg_wdata_i(rwd),
        .reg_ack_o(ack), .reg_err_o(err), .reg_rdata_o(rdata), .satellite_mode_i(sat),
        .memory_response_enable_i(mre), .eeprom_load_i(ld), .eeprom_class_i(ecls),
        .eeprom_revision_i(erev), .eeprom_header_i(ehdr), .pci_addr_valid_i(pv),
        .pci_cmd_i(pcmd), .pci_addr_i(paddr), .pci_hit_o(hit), .pci_hit_prefetch_o(hpf),
        .burst_req_i(breq), .burst_len_i(blen), .read_cmd_valid_o(cv), .read_cmd_o(cmd),
        .master_active_i(mact), .pci_gnt_n_i(gnt_n), .tenure_expired_o(texp),
        .line_size_o(line_o), .bus_tenure_timer_o(tim_o));

    initial
        forever #2.5 clock_i = ~clock_i;

    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [31:0] exp_rd(input logic [15:0] a);
        case (a)
            16'hd008: return {m_cls, m_rev};
            16'hd00c: return {9'h000, m_hdr, m_tim, m_line};
            16'hd010: return b0 | 32'h0000_0008;
            16'hd018: return b1 | 32'h0000_0008;
            16'hd020: return b2;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // One access through the master model, compared and then folded into the model.
    task automatic acc(input logic w, input logic c, input logic [15:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        logic [31:0] bm;
        logic [31:0] mg;
        logic ok;
        int t;
        bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        ok = !sat && a >= 16'hd008 && a <= 16'hd020 && a[1:0] == 2'b00;
        go = 1'b1;
        we = w;
        cfg = c;
        addr = a;
        be = b;
        wdata = d;
        @(posedge clock_i) #1;
        go = 1'b0;
        t = 0;
        do
        begin
            @(posedge clock_i) #1;
            t++;
        end
        while (ack !== 1'b1 && t < 4);
        chk("ack", 1, ack);
        chk("err", !ok, err);
        chk("rdata", (w || !ok) ? 32'h0000_0000 : exp_rd(a), rdata);
        mg = (exp_rd(a) & ~bm) | (d & bm);
        if (w && ok)
            case (a)
                16'hd00c:
                begin
                    m_tim = mg[15:8] & 8'hfc;
                    m_line = mg[7:0];
                end
                16'hd010: b0 = mg & 32'he000_0000;
                16'hd018: b1 = mg & 32'hff00_0000;
                16'hd020: b2 = mg & 32'hfff0_0000;
                default: ;
            endcase
    endtask

    initial
    begin
        #100000;
        err_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(82));
        repeat (5) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        for (int a = 16'hd000; a <= 16'hd024; a += 4)
            acc(1'b0, 1'b0, a[15:0], 4'hf, 32'h0000_0000);
        for (int i = 0; i < 80; i++)
        begin
            k = $urandom_range(0, 6);
            sat = $urandom_range(0, 7) == 0;
            if ($urandom_range(0, 7) == 0)
            begin
                ld = 1'b1;
                ecls = 24'($urandom());
                erev = 8'($urandom());
                ehdr = 7'($urandom());
                @(posedge clock_i) #1;
                ld = 1'b0;
                m_cls = ecls;
                m_rev = erev;
                m_hdr = ehdr;
            end
            acc(ads[k] != 16'hd014 && $urandom_range(0, 1), 1'($urandom()), ads[k], 4'($urandom()),
                $urandom());
            chk("line_size", m_line, line_o);
            chk("tenure_timer", m_tim, tim_o);
        end
        sat = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clock_i) #1;
            bs = '{b0, b1, b2};
            k = $urandom_range(0, 2);
            mre = $urandom_range(0, 3) != 0;
            pcmd = cmds[$urandom_range(0, 6)];
            memc = pcmd inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf};
            paddr = $urandom();
            if ($urandom_range(0, 2) != 0)
                paddr = (paddr & ~msk[k]) | bs[k];
            pv = 1'b1;
            @(posedge clock_i) #1;
            pv = 1'b0;
            for (int j = 0; j < 3; j++)
                eh[j] = mre && memc && ((paddr ^ bs[j]) & msk[j]) == 32'h0000_0000;
            chk("hit", eh, hit);
            chk("prefetch", eh[0] | eh[1], hpf);
        end
        for (int i = 0; i < 24; i++)
        begin
            acc(1'b1, 1'b0, 16'hd00c, 4'h1, ($urandom_range(0, 3) == 0) ? 0 : $urandom_range(1, 20));
            blen = 8'($urandom_range(0, 48));
            breq = 1'b1;
            @(posedge clock_i) #1;
            breq = 1'b0;
            ec = (m_line == 0 || blen < m_line) ? 4'h6 : ({1'b0, blen} >= 2 * m_line) ? 4'hc : 4'he;
            chk("cmd_valid", 1, cv);
            chk("cmd", ec, cmd);
        end
        acc(1'b1, 1'b0, 16'hd00c, 4'h2, 32'h0000_1000);
        mact = 1'b1;
        repeat (8) @(posedge clock_i);
        #1 chk("early_expiry", 0, texp);
        gnt_n = 1'b1;
        n = 0;
        while (texp !== 1'b1 && n < 40)
        begin
            @(posedge clock_i) #1;
            n++;
        end
        chk("tenure_cycles", 1, n >= 16 && n <= 24);
        mact = 1'b0;
        gnt_n = 1'b0;
        repeat (2) @(posedge clock_i) #1;
        chk("tenure_release", 0, texp);
        report_and_stop();
    end
endmodule
